// *** logic/rdr_defines.svh ***
// Offsets, field positions and reset values of the remote DMA block
`ifndef RDR_DEFINES_SVH
`define RDR_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RDR_OFS_CMD 5'h00
`define RDR_OFS_FIRST_PAGE 5'h01
`define RDR_OFS_LAST_PAGE 5'h02
`define RDR_OFS_BOUNDARY 5'h03
`define RDR_OFS_CUR_PAGE 5'h06
`define RDR_OFS_ADDR_LOW 5'h08
`define RDR_OFS_ADDR_HIGH 5'h09
`define RDR_OFS_COUNT_LOW 5'h0A
`define RDR_OFS_COUNT_HIGH 5'h0B
`define RDR_OFS_TX_CFG 5'h0D
`define RDR_OFS_DATA_CFG 5'h0E
`define RDR_OFS_DATA_PORT 5'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RDR_CMD_HALT_BIT 0
`define RDR_CMD_START_BIT 1
`define RDR_CMD_SEND_BIT 2
`define RDR_CMD_RD_LSB 3
`define RDR_CMD_RD_MSB 5
`define RDR_DCFG_WTS_BIT 0
`define RDR_DCFG_BOS_BIT 1
`define RDR_TCFG_LB_LSB 1
`define RDR_TCFG_LB_MSB 2

// ----------------------------------------------------------------------
// Field values and reset values
// ----------------------------------------------------------------------
`define RDR_RD_READ 3'h1
`define RDR_RD_WRITE 3'h2
`define RDR_LB_MAC_INTERNAL 2'h1
`define RDR_RST_BYTE 8'h00
`define RDR_RST_WORD 16'h0000
`define RDR_BYTE_STEP 16'h0001
`define RDR_WORD_STEP 16'h0002

`endif

// *** logic/rdr_pkg.sv ***
// Types shared by the remote DMA block
package rdr_pkg;

    typedef enum logic [1:0]
    {
        RDR_IDLE = 2'b00,
        RDR_READ = 2'b01,
        RDR_WRITE = 2'b10
    } rdr_state_e;

    typedef logic [15:0] rdr_word_t;
    typedef logic [12:0] rdr_index_t;

endpackage

// *** logic/rdr_mem_if.sv ***
// Buffer memory access bundle between the DMA control and the memory
`timescale 1ns/100ps
interface rdr_mem_if;
    import rdr_pkg::*;
    logic we;
    logic [1:0] be;
    rdr_index_t waddr;
    rdr_word_t wdata;
    rdr_index_t raddr;
    rdr_word_t rdata;

    modport ctrl (output we, output be, output waddr, output wdata,
                  output raddr, input rdata);
    modport mem (input we, input be, input waddr, input wdata,
                 input raddr, output rdata);
endinterface

// *** logic/rdr_buffer_mem.sv ***
// Embedded 8K x 16 local buffer memory with byte lane writes
`timescale 1ns/100ps
module rdr_buffer_mem
    import rdr_pkg::*;
(
    // Clock
    input wire logic i_mclk,
    // Memory port
    rdr_mem_if.mem bus
);

    // One array per byte lane, so each lane has a single writer
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_lane
            logic [7:0] lane_q [0:8191];

            // Asynchronous read so a data port read can answer next cycle
            assign bus.rdata[g*8 +: 8] = lane_q[bus.raddr];

            always_ff @(posedge i_mclk)
            begin
                if (bus.we && bus.be[g])
                begin
                    lane_q[bus.waddr] <= bus.wdata[g*8 +: 8];
                end
            end
        end
    endgenerate

endmodule

// *** logic/rdr_top.sv ***
// Remote DMA channel with ring pointers and controller commands
`timescale 1ns/100ps
`include "rdr_defines.svh"
module rdr_top
    import rdr_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Register port
    input wire logic [4:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Local receive DMA side
    input wire logic i_rx_busy,
    input wire logic i_rx_wr,
    input wire logic [15:0] i_rx_addr,
    input wire logic [15:0] i_rx_data,
    input wire logic [1:0] i_rx_be,
    input wire logic i_rx_done,
    input wire logic [7:0] i_rx_next_page,
    // Status and control outputs
    output logic o_halted,
    output logic o_loopback,
    output logic o_tx_start,
    output logic o_rdma_busy,
    output logic o_rdma_done,
    output logic [7:0] o_current_receive_page,
    output logic [7:0] o_ring_boundary_page,
    output logic [7:0] o_ring_first_page,
    output logic [7:0] o_ring_last_page
);

    // ------------------------------------------------------------------
    // Memory
    // ------------------------------------------------------------------
    rdr_mem_if mif ();

    rdr_buffer_mem u_mem
    (
        .i_mclk (i_mclk),
        .bus (mif.mem)
    );

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    rdr_state_e state_q;
    rdr_word_t addr_q;
    rdr_word_t count_q;
    logic [7:0] data_cfg_q;
    logic [7:0] tx_cfg_q;
    logic halted_q;
    logic halt_pend_q;
    logic [2:0] rd_q;

    logic wr_cmd;
    logic wr_port;
    logic rd_port;
    logic word_mode;
    logic byte_swap;
    logic xfer;
    logic rem_we;
    logic rx_we;
    logic [2:0] cmd_rd;
    logic cmd_start;
    logic started_now;
    rdr_word_t step;
    rdr_word_t port_wdata;
    rdr_word_t next_count;
    logic [7:0] rd_byte;

    assign wr_cmd = i_wr && (i_addr == `RDR_OFS_CMD);
    assign wr_port = i_wr && (i_addr == `RDR_OFS_DATA_PORT);
    assign rd_port = i_rd && (i_addr == `RDR_OFS_DATA_PORT);
    assign word_mode = data_cfg_q[`RDR_DCFG_WTS_BIT];
    assign byte_swap = word_mode && data_cfg_q[`RDR_DCFG_BOS_BIT];
    assign cmd_rd = i_wdata[`RDR_CMD_RD_MSB:`RDR_CMD_RD_LSB];
    assign cmd_start = i_wdata[`RDR_CMD_START_BIT];
    // Start in the same write counts as started
    assign started_now = cmd_start ? 1'b1 : !halted_q;
    // one memory transfer per data port strobe in the active direction
    assign xfer = (wr_port && state_q == RDR_WRITE)
        || (rd_port && state_q == RDR_READ);
    assign step = word_mode ? `RDR_WORD_STEP : `RDR_BYTE_STEP;
    // Odd count in word mode ends at zero rather than wrapping
    assign next_count = (count_q > step) ? count_q - step : `RDR_RST_WORD;

    // ------------------------------------------------------------------
    // Memory port steering
    // ------------------------------------------------------------------
    assign rem_we = wr_port && state_q == RDR_WRITE;
    // Remote write wins a clash; local store is the one to give way
    assign rx_we = i_rx_wr && !halted_q && !rem_we;
    assign port_wdata = byte_swap ? {i_wdata[7:0], i_wdata[15:8]}
        : i_wdata;

    always_comb
    begin
        mif.we = rem_we || rx_we;
        mif.waddr = rem_we ? addr_q[13:1] : i_rx_addr[13:1];
        mif.raddr = addr_q[13:1];
        if (rem_we)
        begin
            if (word_mode)
            begin
                mif.be = 2'b11;
                mif.wdata = port_wdata;
            end
            else
            begin
                mif.be = addr_q[0] ? 2'b10 : 2'b01;
                mif.wdata = {i_wdata[7:0], i_wdata[7:0]};
            end
        end
        else
        begin
            mif.be = i_rx_be;
            mif.wdata = i_rx_data;
        end
    end

    // Even byte address sits in the low lane
    assign rd_byte = addr_q[0] ? mif.rdata[15:8] : mif.rdata[7:0];

    // ------------------------------------------------------------------
    // Remote DMA sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q <= RDR_IDLE;
            o_rdma_done <= 1'b0;
        end
        else
        begin
            o_rdma_done <= 1'b0;
            case (state_q)
                RDR_IDLE:
                begin
                    if (wr_cmd && started_now
                        && (cmd_rd == `RDR_RD_READ
                        || cmd_rd == `RDR_RD_WRITE))
                    begin
                        if (count_q == `RDR_RST_WORD)
                        begin
                            o_rdma_done <= 1'b1;
                        end
                        else if (cmd_rd == `RDR_RD_READ)
                        begin
                            state_q <= RDR_READ;
                        end
                        else
                        begin
                            state_q <= RDR_WRITE;
                        end
                    end
                end
                RDR_READ, RDR_WRITE:
                begin
                    if (wr_cmd && (!started_now || cmd_rd[2]))
                    begin
                        state_q <= RDR_IDLE;
                    end
                    else if (halted_q && !wr_cmd)
                    begin
                        // A halt that lands later still ends the operation
                        state_q <= RDR_IDLE;
                    end
                    else if (xfer && next_count == `RDR_RST_WORD)
                    begin
                        state_q <= RDR_IDLE;
                        o_rdma_done <= 1'b1;
                    end
                end
                default:
                begin
                    state_q <= RDR_IDLE;
                end
            endcase
        end
    end

    // Address and count: programmed by register writes in any state, stepped per transfer
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            addr_q <= `RDR_RST_WORD;
            count_q <= `RDR_RST_WORD;
        end
        else if (xfer)
        begin
            addr_q <= addr_q + step;
            count_q <= next_count;
        end
        else if (i_wr)
        begin
            case (i_addr)
                `RDR_OFS_ADDR_LOW: addr_q[7:0] <= i_wdata[7:0];
                `RDR_OFS_ADDR_HIGH: addr_q[15:8] <= i_wdata[7:0];
                `RDR_OFS_COUNT_LOW: count_q[7:0] <= i_wdata[7:0];
                `RDR_OFS_COUNT_HIGH: count_q[15:8] <= i_wdata[7:0];
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Controller commands
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            halted_q <= 1'b1;
            halt_pend_q <= 1'b0;
            rd_q <= `RDR_RD_READ;
            o_tx_start <= 1'b0;
        end
        else
        begin
            o_tx_start <= 1'b0;
            if (wr_cmd)
            begin
                rd_q <= cmd_rd;
                if (i_wdata[`RDR_CMD_HALT_BIT])
                begin
                    halt_pend_q <= 1'b1;
                end
                else if (cmd_start)
                begin
                    halt_pend_q <= 1'b0;
                    halted_q <= 1'b0;
                    o_tx_start <= i_wdata[`RDR_CMD_SEND_BIT];
                end
            end
            else if (halt_pend_q && !i_rx_busy)
            begin
                // Halt lands only after reception in progress finishes
                halted_q <= 1'b1;
                halt_pend_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration and ring pointers
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            data_cfg_q <= `RDR_RST_BYTE;
            tx_cfg_q <= `RDR_RST_BYTE;
            o_ring_first_page <= `RDR_RST_BYTE;
            o_ring_last_page <= `RDR_RST_BYTE;
            o_ring_boundary_page <= `RDR_RST_BYTE;
        end
        else if (i_wr)
        begin
            case (i_addr)
                `RDR_OFS_DATA_CFG: data_cfg_q <= i_wdata[7:0];
                `RDR_OFS_TX_CFG: tx_cfg_q <= i_wdata[7:0];
                `RDR_OFS_FIRST_PAGE: o_ring_first_page <= i_wdata[7:0];
                `RDR_OFS_LAST_PAGE: o_ring_last_page <= i_wdata[7:0];
                `RDR_OFS_BOUNDARY: o_ring_boundary_page <= i_wdata[7:0];
                default:
                begin
                end
            endcase
        end
    end

    // Hardware advance wins over a software write in the same cycle
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_current_receive_page <= `RDR_RST_BYTE;
        end
        else if (i_rx_done && !halted_q)
        begin
            o_current_receive_page <= i_rx_next_page;
        end
        else if (i_wr && i_addr == `RDR_OFS_CUR_PAGE)
        begin
            o_current_receive_page <= i_wdata[7:0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_halted <= 1'b1;
            o_loopback <= 1'b0;
            o_rdma_busy <= 1'b0;
        end
        else
        begin
            o_halted <= halted_q;
            o_loopback <= tx_cfg_q[`RDR_TCFG_LB_MSB:`RDR_TCFG_LB_LSB]
                == `RDR_LB_MAC_INTERNAL;
            o_rdma_busy <= state_q != RDR_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_rdata <= `RDR_RST_WORD;
        end
        else if (i_rd)
        begin
            o_rdata <= `RDR_RST_WORD;
            case (i_addr)
                `RDR_OFS_CMD: o_rdata[7:0] <= {2'b00, rd_q, 1'b0,
                    !halted_q, halted_q};
                `RDR_OFS_FIRST_PAGE: o_rdata[7:0] <= o_ring_first_page;
                `RDR_OFS_LAST_PAGE: o_rdata[7:0] <= o_ring_last_page;
                `RDR_OFS_BOUNDARY: o_rdata[7:0] <= o_ring_boundary_page;
                `RDR_OFS_CUR_PAGE: o_rdata[7:0] <= o_current_receive_page;
                `RDR_OFS_ADDR_LOW: o_rdata[7:0] <= addr_q[7:0];
                `RDR_OFS_ADDR_HIGH: o_rdata[7:0] <= addr_q[15:8];
                `RDR_OFS_DATA_PORT:
                begin
                    if (state_q == RDR_READ)
                    begin
                        if (word_mode)
                        begin
                            o_rdata <= byte_swap
                                ? {mif.rdata[7:0], mif.rdata[15:8]}
                                : mif.rdata;
                        end
                        else
                        begin
                            o_rdata[7:0] <= rd_byte;
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_xfer_mid;
        xfer && count_q > step;
    endsequence

    sequence s_start_zero;
        wr_cmd && started_now && state_q == RDR_IDLE
            && (cmd_rd == `RDR_RD_READ || cmd_rd == `RDR_RD_WRITE)
            && count_q == `RDR_RST_WORD;
    endsequence

    property p_addr_step;
        @(posedge i_mclk) disable iff (!i_nrst)
        s_xfer_mid |=> addr_q == $past(addr_q) + $past(step)
            && count_q == $past(count_q) - $past(step);
    endproperty
    a_addr_step: assert property (p_addr_step)
        else $error("address or count did not step");

    property p_busy_nonzero;
        @(posedge i_mclk) disable iff (!i_nrst)
        state_q != RDR_IDLE |-> count_q != `RDR_RST_WORD;
    endproperty
    a_busy_nonzero: assert property (p_busy_nonzero)
        else $error("active with zero count");

    property p_idle_no_write;
        @(posedge i_mclk) disable iff (!i_nrst)
        state_q == RDR_IDLE && !i_wr
            |=> $stable(addr_q) && $stable(count_q);
    endproperty
    a_idle_no_write: assert property (p_idle_no_write)
        else $error("address or count moved while idle");

    property p_zero_done;
        @(posedge i_mclk) disable iff (!i_nrst)
        s_start_zero |=> o_rdma_done && state_q == RDR_IDLE
            ##1 !o_rdma_done;
    endproperty
    a_zero_done: assert property (p_zero_done)
        else $error("zero count start did not complete");

    property p_halt_waits;
        @(posedge i_mclk) disable iff (!i_nrst)
        halt_pend_q && i_rx_busy && !wr_cmd && !halted_q |=> !halted_q;
    endproperty
    a_halt_waits: assert property (p_halt_waits)
        else $error("halted during reception");

    property p_halted_no_store;
        @(posedge i_mclk) disable iff (!i_nrst)
        halted_q && !rem_we |-> !mif.we;
    endproperty
    a_halted_no_store: assert property (p_halted_no_store)
        else $error("receive store while halted");

    property p_tx_start;
        @(posedge i_mclk) disable iff (!i_nrst)
        o_tx_start |-> $past(wr_cmd) && $past(i_wdata[2:0]) == 3'b110
            ##1 !o_tx_start;
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("transmit start without command");

    property p_swap;
        @(posedge i_mclk) disable iff (!i_nrst)
        rd_port && state_q == RDR_READ && byte_swap
            |=> o_rdata == {$past(mif.rdata[7:0]), $past(mif.rdata[15:8])};
    endproperty
    a_swap: assert property (p_swap)
        else $error("byte lanes not swapped");

    property p_cur_page;
        @(posedge i_mclk) disable iff (!i_nrst)
        i_rx_done && !halted_q |=> o_current_receive_page
            == $past(i_rx_next_page);
    endproperty
    a_cur_page: assert property (p_cur_page)
        else $error("current page did not advance");

    property p_loopback;
        @(posedge i_mclk) disable iff (!i_nrst)
        i_wr && i_addr == `RDR_OFS_TX_CFG && i_wdata[2:1] == 2'b01
            |=> ##1 o_loopback;
    endproperty
    a_loopback: assert property (p_loopback)
        else $error("loopback not selected");

endmodule

// *** bench/rdr_host_model.sv ***
// Host CPU model that drives the register port
`timescale 1ns/100ps
module rdr_host_model
(
    // Clock
    input wire logic i_mclk,
    // Register port
    output logic [4:0] o_addr,
    output logic [15:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    input wire logic [15:0] i_rdata
);
    initial
    begin
        o_addr = 5'h00;
        o_wdata = 16'h0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // ----
    // Bus cycles
    // ----
    // Released data is inverted so a stale value never looks valid
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge i_mclk);
        o_addr <= a;
        o_wdata <= v;
        o_wr <= 1'b1;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        o_wdata <= ~v;
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge i_mclk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_mclk);
        o_rd <= 1'b0;
        #1 v = i_rdata;
    endtask

    // Address and count always precede the command
    task automatic setup(input logic [15:0] sa, n, input logic [7:0] c);
        wr(5'h08, 16'(sa[7:0]));
        wr(5'h09, 16'(sa[15:8]));
        wr(5'h0A, 16'(n[7:0]));
        wr(5'h0B, 16'(n[15:8]));
        wr(5'h00, 16'(c));
    endtask

    task automatic ring(input logic [7:0] f, l);
        wr(5'h01, 16'(f));
        wr(5'h02, 16'(l));
        wr(5'h03, 16'(f));
        wr(5'h06, 16'(f + 8'h01));
    endtask

    function automatic logic [7:0] ring_boundary_page(input logic [7:0] nx, f, l);
        return (nx - 8'h01 < f) ? l - 8'h01 : nx - 8'h01;
    endfunction
endmodule

// *** bench/rdr_top_tb.sv ***
// Self-checking bench for the remote DMA channel
`timescale 1ns/100ps
module rdr_top_tb;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic wr, rd, rxb, rxw, rxd, halted, lpbk, busy;
    logic [4:0] addr;
    logic [15:0] wdat, rdat, rxa, rxv, d;
    logic [7:0] pg, cur, bnd, first, last;
    logic [1:0] fl;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    // Longest reception, 1.5 ms at 50 ns a cycle
    localparam int halt_wait = 30000;
    localparam logic [7:0] hdr [4] = '{8'h01, 8'h49, 8'h40, 8'h00};

    always #25 mclk = ~mclk;

    rdr_host_model host
    (
        .i_mclk(mclk), .o_addr(addr), .o_wdata(wdat),
        .o_wr(wr), .o_rd(rd), .i_rdata(rdat)
    );

    rdr_top uut
    (
        .i_mclk(mclk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdat),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_rx_busy(rxb),
        .i_rx_wr(rxw), .i_rx_addr(rxa), .i_rx_data(rxv),
        .i_rx_be(2'b11), .i_rx_done(rxd), .i_rx_next_page(pg),
        .o_halted(halted), .o_loopback(lpbk), .o_tx_start(fl[1]),
        .o_rdma_busy(busy), .o_rdma_done(fl[0]),
        .o_current_receive_page(cur), .o_ring_boundary_page(bnd),
        .o_ring_first_page(first), .o_ring_last_page(last)
    );

    // ----
    // Helpers
    // ----
    task automatic chk(input logic [15:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic settle();
        @(posedge mclk);
        #1;
    endtask

    // One-cycle flags are polled every cycle, bounded
    task automatic pulse(input int s);
        #1;
        for (int k = 0; k < 4 && fl[s] !== 1'b1; k++)
            settle();
        chk(16'(fl[s]), 16'h1);
    endtask

    // Local receive side: page zero means a store, else packet done
    task automatic rx(input logic [15:0] a, v, input logic [7:0] p);
        @(posedge mclk);
        rxw <= (p == 8'h00);
        rxd <= (p != 8'h00);
        rxa <= a;
        rxv <= v;
        pg <= p;
        @(posedge mclk);
        rxw <= 1'b0;
        rxd <= 1'b0;
        rxv <= ~v;
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        chk(16'(halted), 16'h1);
        host.ring(8'h46, 8'h60);
        settle();
        chk({bnd, cur}, 16'h4647);
        chk({first, last}, 16'h4660);
    endtask

    task automatic t_cmds();
        host.wr(5'h00, 16'h0022);
        settle();
        chk(16'(halted), 16'h0);
        host.rd(5'h00, d);
        chk(d, 16'h0022);
        host.wr(5'h0D, 16'h0002);
        settle();
        chk(16'(lpbk), 16'h1);
        host.wr(5'h0D, 16'h0004);
        settle();
        chk(16'(lpbk), 16'h0);
        host.wr(5'h00, 16'h0026);
        pulse(1);
    endtask

    // Second pass is shorter, so the third old word must survive
    task automatic t_mem();
        host.wr(5'h0E, 16'h0001);
        for (int p = 1; p < 3; p++)
        begin
            host.setup(16'h0100, 16'(8 - 2 * p), 8'h12);
            // One word more than the count allows; the last is refused
            for (int i = 0; i < 5 - p; i++)
            begin
                host.wr(5'h10, {8'(p), 8'(i)});
                #1;
                if (i == 0)
                    chk(16'(busy), 16'h1);
                if (i == 3 - p)
                    pulse(0);
            end
        end
        host.wr(5'h10, 16'h0202);
        host.setup(16'h0100, 16'h0006, 8'h0A);
        for (int i = 0; i < 3; i++)
        begin
            host.rd(5'h10, d);
            chk(d, i < 2 ? {8'h02, 8'(i)} : 16'h0102);
        end
        pulse(0);
        host.rd(5'h10, d);
        chk(d, 16'h0000);
        chk(16'(busy), 16'h0);
        host.rd(5'h08, d);
        chk(d, 16'h0006);
    endtask

    task automatic t_zero();
        host.setup(16'h0300, 16'h0000, 8'h0A);
        pulse(0);
        host.rd(5'h10, d);
        chk(d, 16'h0000);
    endtask

    task automatic t_rx();
        rx(16'h0200, 16'h4901, 8'h00);
        rx(16'h0202, 16'h0040, 8'h00);
        rx(16'h0000, 16'h0000, 8'h49);
        settle();
        chk(16'(cur), 16'h0049);
        host.wr(5'h0E, 16'h0000);
        host.setup(16'h0200, 16'h0004, 8'h0A);
        for (int i = 0; i < 4; i++)
        begin
            host.rd(5'h10, d);
            chk(16'(d[7:0]), 16'(hdr[i]));
        end
        host.rd(5'h08, d);
        chk(d, 16'h0004);
        host.wr(5'h0E, 16'h0003);
        host.setup(16'h0200, 16'h0002, 8'h0A);
        host.rd(5'h10, d);
        chk(d, 16'h0149);
        host.wr(5'h03, 16'(host.ring_boundary_page(cur, first, last)));
        settle();
        chk(16'(bnd), 16'h0048);
        host.wr(5'h03, 16'(host.ring_boundary_page(8'h46, first, last)));
        settle();
        chk(16'(bnd), 16'h005F);
    endtask

    // Halt waits for the reception in flight before landing
    task automatic t_halt();
        @(posedge mclk);
        rxb <= 1'b1;
        host.wr(5'h00, 16'h0021);
        settle();
        chk(16'(halted), 16'h0);
        @(posedge mclk);
        rxb <= 1'b0;
        settle();
        settle();
        chk(16'(halted), 16'h1);
        repeat (halt_wait) @(posedge mclk);
        rx(16'h0200, 16'hDEAD, 8'h00);
        rx(16'h0000, 16'h0000, 8'h50);
        settle();
        chk(16'(cur), 16'h0049);
        host.setup(16'h0200, 16'h0002, 8'h10);
        host.wr(5'h10, 16'hBEEF);
        settle();
        chk(16'(busy), 16'h0);
        host.wr(5'h00, 16'h0022);
        host.wr(5'h0E, 16'h0001);
        host.setup(16'h0200, 16'h0002, 8'h0A);
        host.rd(5'h10, d);
        chk(d, 16'h4901);
    endtask

    initial
    begin
        {rxb, rxw, rxd} = 3'h0;
        rxa = 16'h0000;
        rxv = 16'h0000;
        pg = 8'h00;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        settle();
        t_reset();
        t_cmds();
        t_mem();
        t_zero();
        t_rx();
        t_halt();
        conclude();
    end

    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 31000)
        begin
            fails++;
            conclude();
        end
    end
endmodule
